/* File: verilog/aar_autosleep_readout.sv */
// Auto-sleep controller and acceleration sample register readout
`timescale 1ns/10ps
module aar_autosleep_readout #(
   parameter int STEP_CYCLES = aar_pkg::STEP_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire aar_pkg::aar_reg_req_type reg_req,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic active_mode,
   input wire logic sleep_enable,
   input wire logic hybrid_mode,
   input wire logic fast_read,
   input wire logic hybrid_autoinc,
   input wire logic [2:0] active_rate_field,
   input wire logic [1:0] sleep_rate_field,
   input wire logic [1:0] buffer_mode,
   input wire logic buffer_gate,
   input wire logic buffer_empty,
   input wire logic [10:0] irq_enable,
   input wire logic [10:0] wake_enable,
   input wire logic sleep_irq_route,
   input wire logic [10:0] event_flags,
   input wire logic [7:0] sample_ready_status,
   input wire aar_pkg::aar_accel_type accel_current,
   input wire aar_pkg::aar_accel_type accel_buffer_head,
   input wire aar_pkg::aar_mag_type mag_current,
   output logic [2:0] rate_select,
   output logic [1:0] system_mode,
   output logic [10:0] function_enable,
   output logic buffer_hold,
   output logic buffer_flush,
   output logic irq_pin_one,
   output logic irq_pin_two
);
   import aar_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Address and byte helpers

   function automatic logic is_low_byte(input logic [7:0] a);
      is_low_byte = (a == ADDR_X_LOW) || (a == ADDR_Y_LOW) || (a == ADDR_Z_LOW) ||
                    (a >= ADDR_MAG_FIRST && a <= ADDR_MAG_LAST && a[0] == ADDR_MAG_LAST[0]);
   endfunction

   function automatic logic [7:0] high_of14(input logic [13:0] v);
      high_of14 = v[13:6];
   endfunction

   function automatic logic [7:0] low_of14(input logic [13:0] v);
      low_of14 = {v[5:0], 2'b00};
   endfunction

   // Address that follows a in a burst
   function automatic logic [7:0] next_burst_addr(input logic [7:0] a, input logic fast, input logic hyb);
      logic [7:0] n;
      n = a + 8'h01;
      if (a == ADDR_Z_LOW || (fast && a == ADDR_Z_HIGH)) begin
         n = hyb ? ADDR_MAG_FIRST : ADDR_AFTER_ACCEL;
      end else if (fast && a == ADDR_MAG_LAST - 8'h01) begin
         n = ADDR_AFTER_MAG;
      end else if (fast && is_low_byte(n)) begin
         n = a + 8'h02;
      end
      next_burst_addr = n;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // State

   aar_state_type state;
   aar_state_type next_state;
   logic [7:0] inactivity_limit;
   logic [7:0] next_inactivity_limit;
   logic [7:0] read_ptr;
   logic [7:0] next_read_ptr;
   logic [7:0] next_reg_rdata;
   logic next_reg_rvalid;
   logic sleep_irq;
   logic next_sleep_irq;
   logic gate_error;
   logic next_gate_error;
   logic ready_dropped;
   logic next_ready_dropped;
   logic [10:0] next_function_enable;
   logic next_buffer_flush;
   logic next_irq_pin_one;
   logic next_irq_pin_two;
   logic [2:0] next_rate_select;
   logic [1:0] next_system_mode;
   logic mode_read;
   logic [10:0] qualified;
   logic restart_hit;
   logic wake_hit;
   logic enter_sleep;
   logic leave_sleep;
   logic timer_run;
   logic timer_clear;
   logic long_step;
   logic [2:0] effective_rate;
   logic [7:0] step_count;
   logic buffer_on;

   ////////////////////////////////////////////////////////////////////////////////
   // Inactivity timer

   assign qualified = event_flags & irq_enable;
   assign restart_hit = |(qualified & RESTART_MASK);
   assign wake_hit = |(qualified & wake_enable & WAKE_MASK);
   assign effective_rate = (state == ST_SLEEP) ? (SLEEP_RATE_BASE | {1'b0, sleep_rate_field}) : active_rate_field;
   // Hybrid halves the effective rate; the slowest rate already has the long step
   assign long_step = hybrid_mode || (effective_rate == RATE_SLOWEST);
   assign timer_run = (state == ST_WAKE) && sleep_enable;
   assign timer_clear = (state != ST_WAKE) || !sleep_enable || restart_hit;

   aar_step_timer #(
      .STEP_CYCLES(STEP_CYCLES)
   ) u_step_timer (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .run(timer_run),
      .clear(timer_clear),
      .long_step(long_step),
      .step_count(step_count)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Sleep controller

   always_comb begin
      next_state = state;
      enter_sleep = 1'b0;
      leave_sleep = 1'b0;
      case (state)
         ST_STANDBY: begin
            if (active_mode) begin
               next_state = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (!active_mode) begin
               next_state = ST_STANDBY;
            end else if (sleep_enable && !restart_hit && step_count >= inactivity_limit) begin
               next_state = ST_SLEEP;
               enter_sleep = 1'b1;
            end
         end
         ST_SLEEP: begin
            if (!active_mode) begin
               next_state = ST_STANDBY;
            end else if (wake_hit || !sleep_enable) begin
               next_state = ST_WAKE;
               leave_sleep = 1'b1;
            end
         end
         default: begin
            next_state = ST_STANDBY;
         end
      endcase
   end

   always_comb begin
      // Set wins over the clear by the mode read
      next_sleep_irq = sleep_irq & ~mode_read;
      if ((enter_sleep || leave_sleep) && irq_enable[EV_SLEEP_WAKE]) begin
         next_sleep_irq = 1'b1;
      end
      next_irq_pin_one = next_sleep_irq && sleep_irq_route;
      next_irq_pin_two = next_sleep_irq && !sleep_irq_route;
      // Gate error holds collection until the host has drained the buffer
      next_gate_error = gate_error & ~buffer_empty;
      if (enter_sleep && buffer_gate) begin
         next_gate_error = 1'b1;
      end
      // Without gating an automatic rate change flushes the buffer
      next_buffer_flush = (enter_sleep || leave_sleep) && !buffer_gate;
      // Sample-ready stays off after sleep until software drops its enable
      next_ready_dropped = ready_dropped & irq_enable[EV_SAMPLE_READY];
      if (enter_sleep && irq_enable[EV_SAMPLE_READY]) begin
         next_ready_dropped = 1'b1;
      end
      next_function_enable = irq_enable;
      if (next_state == ST_SLEEP) begin
         next_function_enable = irq_enable & wake_enable & WAKE_MASK;
      end
      if (next_ready_dropped) begin
         next_function_enable[EV_SAMPLE_READY] = 1'b0;
      end
      next_rate_select = active_rate_field;
      next_system_mode = MODE_STANDBY;
      case (next_state)
         ST_WAKE: begin
            next_system_mode = MODE_WAKE;
         end
         ST_SLEEP: begin
            next_system_mode = MODE_SLEEP;
            next_rate_select = SLEEP_RATE_BASE | {1'b0, sleep_rate_field};
         end
         default: begin
            next_system_mode = MODE_STANDBY;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_STANDBY;
         sleep_irq <= 1'b0;
         irq_pin_one <= 1'b0;
         irq_pin_two <= 1'b0;
         gate_error <= 1'b0;
         buffer_flush <= 1'b0;
         ready_dropped <= 1'b0;
         function_enable <= 11'h000;
         rate_select <= 3'h0;
         system_mode <= MODE_STANDBY;
      end else begin
         state <= next_state;
         sleep_irq <= next_sleep_irq;
         irq_pin_one <= next_irq_pin_one;
         irq_pin_two <= next_irq_pin_two;
         gate_error <= next_gate_error;
         buffer_flush <= next_buffer_flush;
         ready_dropped <= next_ready_dropped;
         function_enable <= next_function_enable;
         rate_select <= next_rate_select;
         system_mode <= next_system_mode;
      end
   end

   assign buffer_hold = gate_error;

   ////////////////////////////////////////////////////////////////////////////////
   // Register access

   assign buffer_on = (buffer_mode != BUFFER_OFF);

   function automatic logic [7:0] read_byte(input logic [7:0] a, input logic buf_on, input logic [1:0] mode,
                                            input logic gerr, input logic [7:0] limit, input aar_accel_type cur,
                                            input aar_accel_type head, input aar_mag_type mag,
                                            input logic [7:0] ready);
      logic [7:0] d;
      d = 8'h00;
      if (a == ADDR_SAMPLE_READY) begin
         d = ready;
      end else if (a == ADDR_X_HIGH) begin
         d = buf_on ? high_of14(head.x) : high_of14(cur.x);
      end else if (a >= ADDR_X_LOW && a <= ADDR_Z_LOW) begin
         if (!buf_on) begin
            if (a == ADDR_X_LOW) begin
               d = low_of14(cur.x);
            end else if (a == ADDR_Y_HIGH) begin
               d = high_of14(cur.y);
            end else if (a == ADDR_Y_LOW) begin
               d = low_of14(cur.y);
            end else if (a == ADDR_Z_HIGH) begin
               d = high_of14(cur.z);
            end else begin
               d = low_of14(cur.z);
            end
         end
      end else if (a == ADDR_SYSTEM_MODE) begin
         d = {gerr, 5'b00000, mode};
      end else if (a == ADDR_INACTIVITY_LIMIT) begin
         d = limit;
      end else if (a == ADDR_MAG_FIRST) begin
         d = mag.x[15:8];
      end else if (a == ADDR_MAG_FIRST + 8'h01) begin
         d = mag.x[7:0];
      end else if (a == ADDR_MAG_FIRST + 8'h02) begin
         d = mag.y[15:8];
      end else if (a == ADDR_MAG_FIRST + 8'h03) begin
         d = mag.y[7:0];
      end else if (a == ADDR_MAG_FIRST + 8'h04) begin
         d = mag.z[15:8];
      end else if (a == ADDR_MAG_LAST) begin
         d = mag.z[7:0];
      end
      read_byte = d;
   endfunction

   always_comb begin
      logic [7:0] cur_addr;
      cur_addr = reg_req.start ? reg_req.addr : read_ptr;
      next_read_ptr = cur_addr;
      next_reg_rdata = reg_rdata;
      next_reg_rvalid = 1'b0;
      next_inactivity_limit = inactivity_limit;
      mode_read = 1'b0;
      if (reg_req.rd) begin
         next_reg_rdata = read_byte(cur_addr, buffer_on, system_mode, gate_error, inactivity_limit,
                                    accel_current, accel_buffer_head, mag_current, sample_ready_status);
         next_reg_rvalid = 1'b1;
         next_read_ptr = next_burst_addr(cur_addr, fast_read, hybrid_mode && hybrid_autoinc);
         mode_read = (cur_addr == ADDR_SYSTEM_MODE);
      end else if (reg_req.wr) begin
         if (cur_addr == ADDR_INACTIVITY_LIMIT) begin
            next_inactivity_limit = reg_req.wdata;
         end
         next_read_ptr = cur_addr + 8'h01;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         inactivity_limit <= INACTIVITY_LIMIT_RESET;
         read_ptr <= 8'h00;
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         inactivity_limit <= next_inactivity_limit;
         read_ptr <= next_read_ptr;
         reg_rdata <= next_reg_rdata;
         reg_rvalid <= next_reg_rvalid;
      end
   end

endmodule // aar_autosleep_readout

/* File: verilog/aar_pkg.sv */
// Shared constants and types for the auto-sleep and sample readout block
package aar_pkg;

   // Timebase
   localparam int CLK_FREQ_HZ = 200_000_000;
   localparam int STEP_TIME_MS = 320;
   localparam int STEP_CYCLES = STEP_TIME_MS * (CLK_FREQ_HZ / 1000);
   localparam int LONG_STEP_TIME_MS = 640;
   localparam int LONG_STEP_FACTOR = LONG_STEP_TIME_MS / STEP_TIME_MS;

   // Register offsets
   localparam logic [7:0] ADDR_SAMPLE_READY = 8'h00;
   localparam logic [7:0] ADDR_X_HIGH = 8'h01;
   localparam logic [7:0] ADDR_X_LOW = 8'h02;
   localparam logic [7:0] ADDR_Y_HIGH = 8'h03;
   localparam logic [7:0] ADDR_Y_LOW = 8'h04;
   localparam logic [7:0] ADDR_Z_HIGH = 8'h05;
   localparam logic [7:0] ADDR_Z_LOW = 8'h06;
   localparam logic [7:0] ADDR_AFTER_ACCEL = 8'h07;
   localparam logic [7:0] ADDR_SYSTEM_MODE = 8'h0b;
   localparam logic [7:0] ADDR_INACTIVITY_LIMIT = 8'h29;
   localparam logic [7:0] ADDR_MAG_FIRST = 8'h33;
   localparam logic [7:0] ADDR_MAG_LAST = 8'h38;
   localparam logic [7:0] ADDR_AFTER_MAG = 8'h39;

   // Reset values
   localparam logic [7:0] INACTIVITY_LIMIT_RESET = 8'h00;

   // Rate codes: 0 is the fastest, 7 the slowest (1.56 Hz)
   localparam logic [2:0] RATE_SLOWEST = 3'h7;
   localparam logic [2:0] SLEEP_RATE_BASE = 3'h4;

   // Buffer mode field
   localparam logic [1:0] BUFFER_OFF = 2'h0;

   // Event source indices
   localparam int EV_BUFFER = 0;
   localparam int EV_TRANSIENT = 1;
   localparam int EV_ORIENT = 2;
   localparam int EV_TAP = 3;
   localparam int EV_FALL_MOTION = 4;
   localparam int EV_SLEEP_WAKE = 5;
   localparam int EV_MAGNETIC = 6;
   localparam int EV_SAMPLE_READY = 7;
   localparam int EV_ACCEL_MAG = 8;
   localparam int EV_MAG_MAG = 9;
   localparam int EV_MAG_THRESH = 10;
   localparam int EV_COUNT = 11;
   localparam logic [10:0] RESTART_MASK = 11'h75f;
   localparam logic [10:0] WAKE_MASK = 11'h75e;

   // System mode codes and status layout
   localparam logic [1:0] MODE_STANDBY = 2'h0;
   localparam logic [1:0] MODE_WAKE = 2'h1;
   localparam logic [1:0] MODE_SLEEP = 2'h2;
   localparam int GATE_ERROR_BIT = 7;

   typedef enum logic [1:0] {
      ST_STANDBY = 2'b00,
      ST_WAKE = 2'b01,
      ST_SLEEP = 2'b11
   } aar_state_type;

   typedef struct packed {
      logic [13:0] x;
      logic [13:0] y;
      logic [13:0] z;
   } aar_accel_type;

   typedef struct packed {
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] z;
   } aar_mag_type;

   typedef struct packed {
      logic start;
      logic [7:0] addr;
      logic rd;
      logic wr;
      logic [7:0] wdata;
   } aar_reg_req_type;

endpackage

/* File: verilog/aar_step_timer.sv */
// Inactivity step counter: counts whole 320 ms or 640 ms steps
`timescale 1ns/10ps
module aar_step_timer #(
   parameter int STEP_CYCLES = aar_pkg::STEP_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic clear,
   input wire logic long_step,
   output logic [7:0] step_count
);
   import aar_pkg::*;

   logic [31:0] prescale;
   logic [31:0] next_prescale;
   logic [1:0] half;
   logic [1:0] next_half;
   logic [7:0] next_step_count;

   always_comb begin
      next_prescale = prescale;
      next_half = half;
      next_step_count = step_count;
      if (clear) begin
         next_prescale = 32'h0;
         next_half = 2'h0;
         next_step_count = 8'h00;
      end else if (run) begin
         if (prescale == 32'(STEP_CYCLES - 1)) begin
            next_prescale = 32'h0;
            // A long step is two base periods
            if (!long_step || half == 2'(LONG_STEP_FACTOR - 1)) begin
               next_half = 2'h0;
               if (step_count != 8'hff) begin
                  next_step_count = step_count + 8'h01;
               end
            end else begin
               next_half = half + 2'h1;
            end
         end else begin
            next_prescale = prescale + 32'h1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prescale <= 32'h0;
         half <= 2'h0;
         step_count <= 8'h00;
      end else begin
         prescale <= next_prescale;
         half <= next_half;
         step_count <= next_step_count;
      end
   end

endmodule // aar_step_timer

/* File: dv/aar_checker.sv */
// Port-level assertions for the auto-sleep and readout block
`timescale 1ns/10ps
module aar_checker (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire aar_pkg::aar_reg_req_type reg_req,
   input wire logic reg_rvalid,
   input wire logic active_mode,
   input wire logic sleep_enable,
   input wire logic [2:0] active_rate_field,
   input wire logic [1:0] sleep_rate_field,
   input wire logic buffer_gate,
   input wire logic [10:0] irq_enable,
   input wire logic [10:0] wake_enable,
   input wire logic sleep_irq_route,
   input wire logic [10:0] event_flags,
   input wire logic [2:0] rate_select,
   input wire logic [1:0] system_mode,
   input wire logic buffer_hold,
   input wire logic irq_pin_one,
   input wire logic irq_pin_two
);
   import aar_pkg::*;
   logic pin;
   logic restart_hit;
   logic wake_hit;
   assign pin = irq_pin_one | irq_pin_two;
   assign restart_hit = |(event_flags & irq_enable & RESTART_MASK);
   assign wake_hit = |(event_flags & irq_enable & wake_enable & WAKE_MASK);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////////
   a_read_answer: assert property (reg_req.rd |=> reg_rvalid)
      else $error("read not answered");
   a_no_stray_valid: assert property (!reg_req.rd |=> !reg_rvalid)
      else $error("stray read valid");
   a_sleep_rate: assert property (system_mode == MODE_SLEEP && $stable(sleep_rate_field)
      |-> rate_select == SLEEP_RATE_BASE + {1'b0, sleep_rate_field}) else $error("wrong sleep rate");
   a_wake_rate: assert property (system_mode == MODE_WAKE && $stable(active_rate_field)
      |-> rate_select == active_rate_field) else $error("wrong wake rate");
   a_route_pins: assert property ($stable(sleep_irq_route)
      |-> (sleep_irq_route ? !irq_pin_two : !irq_pin_one)) else $error("sleep irq on wrong pin");
   a_irq_on_change: assert property ($past(irq_enable[EV_SLEEP_WAKE]) && $changed(system_mode)
      && system_mode != MODE_STANDBY && $past(system_mode) != MODE_STANDBY |-> pin) else $error("no sleep irq");
   a_irq_cause: assert property ($rose(pin) |-> $changed(system_mode) && $past(irq_enable[EV_SLEEP_WAKE]))
      else $error("sleep irq without cause");
   a_irq_clear: assert property (reg_req.rd && reg_req.start && reg_req.addr == ADDR_SYSTEM_MODE
      ##1 $stable(system_mode) |-> !pin) else $error("sleep irq not cleared");
   a_sleep_cause: assert property (system_mode == MODE_SLEEP && $past(system_mode) == MODE_WAKE
      |-> $past(sleep_enable) && !$past(restart_hit)) else $error("bad sleep entry");
   a_wake_cause: assert property (system_mode == MODE_WAKE && $past(system_mode) == MODE_SLEEP
      |-> !$past(sleep_enable) || !$past(active_mode) || $past(wake_hit) || $past(wake_hit, 2))
      else $error("wake without cause");
   a_gate_hold: assert property ($rose(buffer_hold) |-> system_mode == MODE_SLEEP && $past(buffer_gate))
      else $error("buffer hold without gated sleep");
endmodule // aar_checker

bind aar_autosleep_readout aar_checker aar_checker_i (.sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req),
   .reg_rvalid(reg_rvalid), .active_mode(active_mode), .sleep_enable(sleep_enable),
   .active_rate_field(active_rate_field), .sleep_rate_field(sleep_rate_field), .buffer_gate(buffer_gate),
   .irq_enable(irq_enable), .wake_enable(wake_enable), .sleep_irq_route(sleep_irq_route),
   .event_flags(event_flags), .rate_select(rate_select), .system_mode(system_mode),
   .buffer_hold(buffer_hold), .irq_pin_one(irq_pin_one), .irq_pin_two(irq_pin_two));

/* File: dv/aar_host_model.sv */
// Host processor model issuing register accesses
`timescale 1ns/10ps
module aar_host_model (
   input wire logic sys_clk,
   output aar_pkg::aar_reg_req_type reg_req,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid
);
   import aar_pkg::*;
   initial reg_req = '0;
   // Mode reads and drains clear sleep irq and gate error
   task automatic access(input logic [7:0] a, input logic st, input logic w, input logic [7:0] d,
      input int gap, output logic [7:0] q, output logic ok);
      int n;
      repeat (gap + 1) @(negedge sys_clk);
      reg_req = '{start: st, addr: a, rd: !w, wr: w, wdata: d};
      @(negedge sys_clk);
      // Idle lines carry junk so stale values never look valid
      reg_req = '{start: 1'b0, addr: ~a, rd: 1'b0, wr: 1'b0, wdata: ~d};
      q = 8'h00;
      ok = w;
      for (n = 0; n < 3 && !ok; n++) begin
         if (reg_rvalid === 1'b1) begin
            q = reg_rdata;
            ok = 1'b1;
         end else begin
            @(negedge sys_clk);
         end
      end
   endtask
endmodule // aar_host_model

/* File: dv/aar_autosleep_readout_test.sv */
// Self-checking bench for the auto-sleep controller and sample readout
`timescale 1ns/10ps
module aar_autosleep_readout_test;
   import aar_pkg::*;
   localparam int STEP = 4;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   aar_reg_req_type reg_req;
   logic [7:0] reg_rdata, sample_ready_status, q, lim, a;
   logic reg_rvalid, active_mode, sleep_enable, hybrid_mode, fast_read, hybrid_autoinc, buffer_gate, ok;
   logic buffer_empty, sleep_irq_route, buffer_hold, buffer_flush, irq_pin_one, irq_pin_two, hit;
   logic [2:0] active_rate_field, rate_select;
   logic [1:0] sleep_rate_field, buffer_mode, system_mode;
   logic [10:0] irq_enable, wake_enable, event_flags, function_enable;
   aar_accel_type accel_current, accel_buffer_head;
   aar_mag_type mag_current;
   int failures = 0, comparisons = 0, seed = 32'ha23d, n, k, j;

   always #2.5 sys_clk = ~sys_clk;

   aar_autosleep_readout #(.STEP_CYCLES(STEP)) aar_autosleep_readout_i (.*);
   aar_host_model aar_host_model_i (.*);

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] exp_byte(input logic [7:0] ad);
      aar_accel_type s;
      logic [13:0] v;
      logic [15:0] m;
      s = (buffer_mode != BUFFER_OFF) ? accel_buffer_head : accel_current;
      v = (ad < 8'h03) ? s.x : (ad < 8'h05) ? s.y : s.z;
      m = (ad < 8'h35) ? mag_current.x : (ad < 8'h37) ? mag_current.y : mag_current.z;
      if (ad == ADDR_SAMPLE_READY) return sample_ready_status;
      if (ad <= ADDR_Z_LOW) return (buffer_mode != BUFFER_OFF && ad != ADDR_X_HIGH) ? 8'h00 :
         ad[0] ? v[13:6] : {v[5:0], 2'b00};
      if (ad >= ADDR_MAG_FIRST && ad <= ADDR_MAG_LAST) return ad[0] ? m[15:8] : m[7:0];
      return 8'h00;
   endfunction

   function automatic logic [7:0] nxt(input logic [7:0] ad);
      if (ad == ADDR_Z_LOW || (fast_read && ad == ADDR_Z_HIGH))
         return (hybrid_mode && hybrid_autoinc) ? ADDR_MAG_FIRST : ADDR_AFTER_ACCEL;
      return ad + ((fast_read && ad != ADDR_SAMPLE_READY) ? 8'h02 : 8'h01);
   endfunction

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic check_cnt(input int got, input int lo, input int hi);
      comparisons++;
      if (got < lo || got > hi) begin
         failures++;
         $display("ERROR %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
      end
   endtask

   task automatic wrap_up();
      if (failures == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Random gaps vary host pacing
   task automatic rd(input logic [7:0] ad, input logic st);
      aar_host_model_i.access(ad, st, 1'b0, 8'h00, $unsigned($random(seed)) % 3, q, ok);
      check({7'h0, ok}, 8'h01);
   endtask

   task automatic wait_mode(input logic [1:0] m, input int bound);
      n = 0;
      while (system_mode !== m && n < bound) begin
         @(negedge sys_clk);
         n++;
      end
      if (system_mode !== m) begin
         failures++;
         $display("ERROR %0t: mode wait timed out", $time);
         wrap_up();
      end
   endtask

   task automatic pulse(input int idx);
      event_flags[idx] = 1'b1;
      @(negedge sys_clk);
      event_flags = '0;
   endtask

   // Standby first for a clean wake entry
   task automatic enter_wake(input logic [2:0] rate, input logic hyb, input logic [7:0] l, input logic route);
      active_mode = 1'b0;
      repeat (2) @(negedge sys_clk);
      rd(ADDR_SYSTEM_MODE, 1'b1);
      aar_host_model_i.access(ADDR_INACTIVITY_LIMIT, 1'b1, 1'b1, l, 0, q, ok);
      active_rate_field = rate;
      hybrid_mode = hyb;
      sleep_irq_route = route;
      active_mode = 1'b1;
      wait_mode(MODE_WAKE, 10);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {active_mode, hybrid_mode, fast_read, hybrid_autoinc, buffer_gate, buffer_empty, sleep_irq_route} = '0;
      sleep_enable = 1'b1;
      {active_rate_field, sleep_rate_field, buffer_mode, event_flags} = '0;
      irq_enable = '1;
      wake_enable = '1;
      sample_ready_status = 8'($random(seed));
      accel_current = 42'({$random(seed), $random(seed)});
      accel_buffer_head = 42'({$random(seed), $random(seed)});
      mag_current = 48'({$random(seed), $random(seed)});
      repeat (5) @(negedge sys_clk);
      rst_n = 1'b1;
      rd(ADDR_INACTIVITY_LIMIT, 1'b1);
      check(q, INACTIVITY_LIMIT_RESET);
      lim = 8'($random(seed));
      aar_host_model_i.access(ADDR_INACTIVITY_LIMIT, 1'b1, 1'b1, lim, 0, q, ok);
      aar_host_model_i.access(ADDR_X_HIGH, 1'b1, 1'b1, ~lim, 0, q, ok);
      rd(ADDR_INACTIVITY_LIMIT, 1'b1);
      check(q, lim);
      rd(ADDR_X_HIGH, 1'b1);
      check(q, exp_byte(ADDR_X_HIGH));
      for (k = 0; k < 4; k++) begin
         {hybrid_mode, fast_read} = 2'(k);
         hybrid_autoinc = hybrid_mode;
         a = ADDR_SAMPLE_READY;
         for (j = 0; j < 1 + (fast_read ? 3 : 6) * (hybrid_mode ? 2 : 1); j++) begin
            rd(a, j == 0);
            check(q, exp_byte(a));
            a = nxt(a);
         end
      end
      rd(ADDR_Y_LOW, 1'b1);
      check(q, exp_byte(ADDR_Y_LOW));
      fast_read = 1'b0;
      buffer_mode = 2'h1 + 2'($unsigned($random(seed)) % 3);
      for (a = ADDR_X_HIGH; a <= ADDR_Z_LOW; a++) begin
         rd(a, 1'b1);
         check(q, exp_byte(a));
      end
      buffer_mode = BUFFER_OFF;
      for (k = 0; k < 3; k++) begin
         lim = 8'(2 + $unsigned($random(seed)) % 3);
         sleep_rate_field = 2'($random(seed));
         enter_wake(k == 1 ? RATE_SLOWEST : 3'h2, k == 2, lim, k[0]);
         wait_mode(MODE_SLEEP, 200);
         check_cnt(n, lim * STEP * (k == 0 ? 1 : 2), lim * STEP * (k == 0 ? 1 : 2) + 5);
         check({5'h0, rate_select}, {5'h0, SLEEP_RATE_BASE + {1'b0, sleep_rate_field}});
         check({5'h0, buffer_flush, irq_pin_one, irq_pin_two}, k[0] ? 8'h06 : 8'h05);
         rd(ADDR_SYSTEM_MODE, 1'b1);
         check(q, {6'h0, MODE_SLEEP});
         check({6'h0, irq_pin_one, irq_pin_two}, 8'h00);
      end
      for (j = 0; j < EV_COUNT; j++) begin
         wake_enable = '0;
         irq_enable = '1;
         irq_enable[j] = 1'($random(seed));
         enter_wake(3'h2, 1'b0, 8'h02, 1'b0);
         repeat (6) begin
            pulse(j);
            repeat (3) @(negedge sys_clk);
         end
         hit = RESTART_MASK[j] && irq_enable[j];
         check({6'h0, system_mode}, {6'h0, hit ? MODE_WAKE : MODE_SLEEP});
      end
      for (j = 0; j < EV_COUNT; j++) begin
         irq_enable = '1;
         wake_enable = '1;
         irq_enable[j] = 1'($random(seed));
         wake_enable[j] = 1'($random(seed));
         enter_wake(3'h1, 1'b0, 8'h03, 1'b1);
         wait_mode(MODE_SLEEP, 40);
         pulse(j);
         repeat (2) @(negedge sys_clk);
         hit = WAKE_MASK[j] && irq_enable[j] && wake_enable[j];
         check({6'h0, system_mode}, {6'h0, hit ? MODE_WAKE : MODE_SLEEP});
         if (hit) check({5'h0, rate_select}, {5'h0, active_rate_field});
         check({7'h0, function_enable === (irq_enable & (hit ? ~11'h080 : wake_enable & WAKE_MASK))}, 8'h01);
      end
      irq_enable = '1;
      wake_enable = '1;
      buffer_gate = 1'b1;
      enter_wake(3'h0, 1'b0, 8'h02, 1'b0);
      wait_mode(MODE_SLEEP, 40);
      check({6'h0, buffer_hold, buffer_flush}, 8'h02);
      rd(ADDR_SYSTEM_MODE, 1'b1);
      check(q, {1'b1, 5'h0, MODE_SLEEP});
      pulse(EV_TRANSIENT);
      repeat (2) @(negedge sys_clk);
      check({6'h0, system_mode}, {6'h0, MODE_WAKE});
      buffer_empty = 1'b1;
      repeat (3) @(negedge sys_clk);
      check({7'h0, buffer_hold}, 8'h00);
      wait_mode(MODE_SLEEP, 20);
      sleep_enable = 1'b0;
      repeat (2) @(negedge sys_clk);
      check({6'h0, system_mode}, {6'h0, MODE_WAKE});
      rst_n = 1'b0;
      @(negedge sys_clk);
      rst_n = 1'b1;
      check({6'h0, system_mode}, {6'h0, MODE_STANDBY});
      rd(ADDR_INACTIVITY_LIMIT, 1'b1);
      check(q, INACTIVITY_LIMIT_RESET);
      wrap_up();
   end

   initial begin
      repeat (100000) @(posedge sys_clk);
      failures++;
      wrap_up();
   end
endmodule // aar_autosleep_readout_test
